/* File: core/srcs_pkg.sv */
// Purpose: constants and types for the reset and clock-start sequencer
// Assumes: one reference clock, registers reached over a plain strobe port
// Notes: the vector values are addresses of the reset vector pair
package srcs_pkg;
  localparam int unsigned REF_CLOCK_MHZ = 200;
  localparam int unsigned STARTUP_CYCLES = 4096;
  localparam int unsigned PIN_DRIVE_CYCLES = 32;
  localparam int unsigned INTERNAL_RESET_EXTRA_CYCLES = 32;
  localparam int unsigned PIN_FLAG_CYCLES = 67;
  localparam int unsigned PIN_FLAG_POR_CYCLES = 4163;
  localparam int unsigned PRESCALER_WIDTH = 13;
  localparam logic [15:0] VECTOR_USER = 16'hfffe;
  localparam logic [15:0] VECTOR_MONITOR = 16'hfefe;
  localparam logic [15:0] WDOG_SERVICE_ADDR = 16'hffff;
  localparam logic [15:0] CAUSE_REG_ADDR = 16'hfe01;
  localparam logic [15:0] WDOG_LIMIT_ADDR = 16'hfe02;
  localparam logic [7:0] CAUSE_RESET = 8'h80;
  localparam logic [7:0] WDOG_LIMIT_RESET = 8'hff;
  localparam logic [12:0] PRESCALER_RESET = 13'h0000;
  localparam logic [12:0] SERVICE_KEEP_MASK = 13'h000f;
  localparam int unsigned CAUSE_POR_BIT = 7;
  localparam int unsigned CAUSE_PIN_BIT = 6;
  localparam int unsigned CAUSE_WDOG_BIT = 5;
  localparam int unsigned CAUSE_ILLEGAL_OPCODE_FLAG_BIT = 4;
  localparam int unsigned CAUSE_ILLEGAL_ADDRESS_FLAG_BIT = 3;
  localparam int unsigned CAUSE_LVR_BIT = 1;

  typedef enum logic [2:0] {
    SRCS_STARTUP = 3'b000,
    SRCS_PIN_DRIVE = 3'b001,
    SRCS_INTERNAL_RESET_HOLD = 3'b011,
    SRCS_RUN = 3'b010,
    SRCS_EXT_HOLD = 3'b110
  } srcs_state_t;

  typedef struct packed {
    logic por;
    logic pin;
    logic wdog;
    logic illegal_opcode_flag;
    logic illegal_address_flag;
    logic lvr;
  } srcs_cause_t;
endpackage

/* File: core/srcs_top.sv */
// Purpose: reset gathering, reset pin sequencing, clock start and watchdog
// Assumes: i_mclk is the crystal reference clock; power-on arrives on i_resetn
// Notes: reset pin is open drain; o_rst_pin_oe high pulls the pin low
`timescale 1ns/1ps
module srcs_top #(
  parameter int unsigned STARTUP_COUNT = srcs_pkg::STARTUP_CYCLES,
  parameter int unsigned PIN_FLAG_POR_COUNT = srcs_pkg::PIN_FLAG_POR_CYCLES
) (
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_pll_select,
  input wire logic i_pll_vco_clock,
  input wire logic i_low_voltage_reset,
  input wire logic i_illegal_opcode,
  input wire logic i_illegal_fetch,
  input wire logic i_opcode_fetch,
  input wire logic i_wait_mode,
  input wire logic i_monitor_mode,
  input wire logic i_break_state,
  input wire logic i_rst_pin_high_voltage,
  input wire logic i_irq_pin_high_voltage,
  input wire logic i_rst_pin,
  input wire logic [15:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  output logic o_rst_pin_out,
  output logic o_rst_pin_oe,
  output logic o_internal_reset_n,
  output logic o_cpu_release,
  output logic o_clock_gen_enable,
  output logic o_clock_gen_output,
  output logic o_bus_clk_en,
  output logic o_cpu_clk_en,
  output logic o_periph_clk_en_a,
  output logic o_periph_clk_en_b,
  output logic [15:0] o_reset_vector,
  output logic o_halt,
  output logic o_wdog_disabled,
  output logic [12:0] o_prescaler
);
  localparam int unsigned CW = 13;
  localparam logic [CW-1:0] STARTUP_LAST = CW'(STARTUP_COUNT - 1);
  localparam logic [CW-1:0] DRIVE_LAST = CW'(srcs_pkg::PIN_DRIVE_CYCLES - 1);
  localparam logic [CW-1:0] HOLD_LAST = CW'(srcs_pkg::INTERNAL_RESET_EXTRA_CYCLES - 1);
  localparam logic [CW-1:0] PIN_LAST = CW'(srcs_pkg::PIN_FLAG_CYCLES - 1);
  localparam logic [CW-1:0] PIN_POR_LAST = CW'(PIN_FLAG_POR_COUNT - 1);

  // three-flop synchronisers for pin and low voltage
  logic [2:0] pin_sync, next_pin_sync;
  logic [2:0] lvr_sync, next_lvr_sync;
  logic pin_low, next_pin_low;
  logic lvr_level, next_lvr_level;

  always_comb begin
    next_pin_sync = {pin_sync[1:0], i_rst_pin};
    next_lvr_sync = {lvr_sync[1:0], i_low_voltage_reset};
    next_pin_low = pin_low;
    if (pin_sync[1] == pin_sync[2]) begin
      next_pin_low = ~pin_sync[2];
    end
    next_lvr_level = lvr_level;
    if (lvr_sync[1] == lvr_sync[2]) begin
      next_lvr_level = lvr_sync[2];
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      pin_sync <= 3'h7;
      lvr_sync <= 3'h0;
      pin_low <= 1'b0;
      lvr_level <= 1'b0;
    end else begin
      pin_sync <= next_pin_sync;
      lvr_sync <= next_lvr_sync;
      pin_low <= next_pin_low;
      lvr_level <= next_lvr_level;
    end
  end

  // prescaler on the falling reference edge
  logic [CW-1:0] prescaler, next_prescaler;
  logic service_write;
  logic internal_source;
  logic clear_prescaler;
  logic presc_tick, next_presc_tick;
  srcs_pkg::srcs_state_t state, next_state;

  assign service_write = i_wr && (i_addr == srcs_pkg::WDOG_SERVICE_ADDR);

  always_comb begin
    next_prescaler = prescaler + CW'(1);
    if (clear_prescaler) begin
      next_prescaler = srcs_pkg::PRESCALER_RESET;
    end else if (service_write) begin
      next_prescaler = prescaler & srcs_pkg::SERVICE_KEEP_MASK;
    end
    next_presc_tick = (prescaler == {CW{1'b1}}) && !clear_prescaler;
  end

  always_ff @(negedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      prescaler <= srcs_pkg::PRESCALER_RESET;
      presc_tick <= 1'b0;
    end else begin
      prescaler <= next_prescaler;
      presc_tick <= next_presc_tick;
    end
  end

  // watchdog counter with a software limit
  logic [7:0] wdog_count, next_wdog_count;
  logic [7:0] wdog_limit, next_wdog_limit;
  logic wdog_tick_d, next_wdog_tick_d;
  logic wdog_fire;
  logic wdog_disabled;
  logic in_reset;

  // purely combinational so noise on a register cannot disable it
  assign wdog_disabled = (i_monitor_mode && (i_rst_pin_high_voltage
      || i_irq_pin_high_voltage))
      || (i_break_state && i_rst_pin_high_voltage);

  always_comb begin
    next_wdog_tick_d = presc_tick;
    next_wdog_count = wdog_count;
    next_wdog_limit = wdog_limit;
    wdog_fire = 1'b0;
    if (in_reset || wdog_disabled || service_write) begin
      next_wdog_count = 8'h00;
    end else if (presc_tick && !wdog_tick_d) begin
      if (wdog_count == wdog_limit) begin
        wdog_fire = 1'b1;
        next_wdog_count = 8'h00;
      end else begin
        next_wdog_count = wdog_count + 8'h01;
      end
    end
    if (in_reset) begin
      next_wdog_limit = srcs_pkg::WDOG_LIMIT_RESET;
    end else if (i_wr && (i_addr == srcs_pkg::WDOG_LIMIT_ADDR)) begin
      next_wdog_limit = i_wdata;
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      wdog_count <= 8'h00;
      wdog_limit <= srcs_pkg::WDOG_LIMIT_RESET;
      wdog_tick_d <= 1'b0;
    end else begin
      wdog_count <= next_wdog_count;
      wdog_limit <= next_wdog_limit;
      wdog_tick_d <= next_wdog_tick_d;
    end
  end

  // reset sequencer
  logic [CW-1:0] count, next_count;
  logic [CW-1:0] pin_count, next_pin_count;
  logic power_reset, next_power_reset;
  logic lvr_seen, next_lvr_seen;
  srcs_pkg::srcs_cause_t cause, next_cause;
  logic illegal_opcode_flag_evt;
  logic illegal_address_flag_evt;
  logic lvr_evt;
  logic pin_limit_hit;

  assign illegal_opcode_flag_evt = i_illegal_opcode;
  assign illegal_address_flag_evt = i_illegal_fetch && i_opcode_fetch;
  assign lvr_evt = lvr_level && !lvr_seen;
  assign internal_source = illegal_opcode_flag_evt || illegal_address_flag_evt || wdog_fire || lvr_evt;
  assign clear_prescaler = internal_source || state == srcs_pkg::SRCS_STARTUP;
  assign in_reset = state != srcs_pkg::SRCS_RUN;
  assign pin_limit_hit = power_reset ? (pin_count >= PIN_POR_LAST)
      : (pin_count >= PIN_LAST);

  always_comb begin
    next_state = state;
    next_count = count + CW'(1);
    next_cause = cause;
    next_power_reset = power_reset;
    next_lvr_seen = lvr_level;
    next_pin_count = pin_low ? pin_count + CW'(1) : '0;
    if (pin_count == {CW{1'b1}}) begin
      next_pin_count = pin_count;
    end
    if (pin_low && pin_limit_hit && !power_reset) begin
      next_cause.pin = 1'b1;
    end
    if (state == srcs_pkg::SRCS_RUN && internal_source) begin
      next_cause = '0;
      next_cause.wdog = wdog_fire;
      next_cause.illegal_opcode_flag = illegal_opcode_flag_evt;
      next_cause.illegal_address_flag = illegal_address_flag_evt;
      next_cause.lvr = lvr_evt;
      next_count = '0;
      next_power_reset = lvr_evt;
      next_state = lvr_evt ? srcs_pkg::SRCS_STARTUP : srcs_pkg::SRCS_PIN_DRIVE;
    end else begin
      case (state)
        srcs_pkg::SRCS_STARTUP: begin
          if (count == STARTUP_LAST) begin
            next_count = '0;
            next_state = srcs_pkg::SRCS_PIN_DRIVE;
          end
        end
        srcs_pkg::SRCS_PIN_DRIVE: begin
          if (count == DRIVE_LAST) begin
            next_count = '0;
            next_state = srcs_pkg::SRCS_INTERNAL_RESET_HOLD;
          end
        end
        srcs_pkg::SRCS_INTERNAL_RESET_HOLD: begin
          if (pin_low) begin
            next_count = '0;
          end else if (count == HOLD_LAST) begin
            next_count = '0;
            next_power_reset = 1'b0;
            next_state = srcs_pkg::SRCS_RUN;
          end
        end
        srcs_pkg::SRCS_RUN: begin
          next_count = '0;
          if (pin_low) begin
            next_state = srcs_pkg::SRCS_EXT_HOLD;
          end
        end
        srcs_pkg::SRCS_EXT_HOLD: begin
          next_count = '0;
          if (!pin_low) begin
            next_state = srcs_pkg::SRCS_INTERNAL_RESET_HOLD;
          end
        end
        default: begin
          next_state = srcs_pkg::SRCS_STARTUP;
        end
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      state <= srcs_pkg::SRCS_STARTUP;
      count <= '0;
      pin_count <= '0;
      power_reset <= 1'b1;
      lvr_seen <= 1'b0;
      cause <= srcs_pkg::srcs_cause_t'(6'h20);
    end else begin
      state <= next_state;
      count <= next_count;
      pin_count <= next_pin_count;
      power_reset <= next_power_reset;
      lvr_seen <= next_lvr_seen;
      cause <= next_cause;
    end
  end

  // bus clocks: generator output halved gives the bus phase
  logic gen_div, next_gen_div;
  logic bus_phase, next_bus_phase;
  logic gen_src;
  logic [7:0] rdata, next_rdata;

  assign gen_src = i_pll_select ? i_pll_vco_clock : 1'b1;

  always_comb begin
    next_gen_div = gen_div;
    next_bus_phase = bus_phase;
    if (state == srcs_pkg::SRCS_STARTUP) begin
      next_gen_div = 1'b0;
      next_bus_phase = 1'b0;
    end else if (gen_src) begin
      next_gen_div = ~gen_div;
      if (gen_div) begin
        next_bus_phase = ~bus_phase;
      end
    end
    next_rdata = 8'h00;
    if (i_rd && i_addr == srcs_pkg::CAUSE_REG_ADDR) begin
      next_rdata = {cause.por, cause.pin, cause.wdog, cause.illegal_opcode_flag, cause.illegal_address_flag,
          1'b0, cause.lvr, 1'b0};
    end else if (i_rd && i_addr == srcs_pkg::WDOG_LIMIT_ADDR) begin
      next_rdata = wdog_limit;
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      gen_div <= 1'b0;
      bus_phase <= 1'b0;
      rdata <= 8'h00;
    end else begin
      gen_div <= next_gen_div;
      bus_phase <= next_bus_phase;
      rdata <= next_rdata;
    end
  end

  logic bus_tick;
  assign bus_tick = gen_src && gen_div && !bus_phase && !in_reset;
  assign o_rdata = rdata;
  assign o_rst_pin_out = 1'b0;
  assign o_rst_pin_oe = state == srcs_pkg::SRCS_STARTUP
      || state == srcs_pkg::SRCS_PIN_DRIVE;
  assign o_internal_reset_n = !in_reset;
  assign o_cpu_release = !in_reset;
  assign o_clock_gen_enable = 1'b1;
  assign o_clock_gen_output = gen_div;
  assign o_bus_clk_en = bus_tick;
  assign o_cpu_clk_en = bus_tick && !i_wait_mode;
  assign o_periph_clk_en_a = bus_tick;
  assign o_periph_clk_en_b = gen_src && gen_div && bus_phase && !in_reset;
  assign o_reset_vector = i_monitor_mode ? srcs_pkg::VECTOR_MONITOR
      : srcs_pkg::VECTOR_USER;
  assign o_halt = in_reset || pin_low;
  assign o_wdog_disabled = wdog_disabled;
  assign o_prescaler = prescaler;
endmodule

/* File: verification/srcs_partner.sv */
// Purpose: far side of the open-drain reset pin
// Assumes: the pin has a pull-up; an outside party may hold it low
// Notes: the level is the wired-and of every pull-down
`timescale 1ns/1ps
module srcs_partner (
  input wire logic i_oe,
  input wire logic i_out,
  input wire logic i_hold_low,
  output logic o_pin
);
  // pull-up wins only when nobody pulls down
  assign o_pin = !((i_oe && !i_out) || i_hold_low);
endmodule

/* File: verification/srcs_checker.sv */
// Purpose: port-level checks of the reset sequencer
// Assumes: one clock domain, reset active low
// Notes: oe_len counts how long o_rst_pin_oe has pulled the pin low
`timescale 1ns/1ps
module srcs_checker #(
  parameter int unsigned STARTUP_COUNT = 4096
) (
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_wait_mode,
  input wire logic i_monitor_mode,
  input wire logic i_break_state,
  input wire logic i_rst_pin_high_voltage,
  input wire logic i_irq_pin_high_voltage,
  input wire logic i_rst_pin,
  input wire logic [15:0] i_addr,
  input wire logic i_wr,
  input wire logic o_rst_pin_out,
  input wire logic o_rst_pin_oe,
  input wire logic o_internal_reset_n,
  input wire logic o_cpu_clk_en,
  input wire logic [15:0] o_reset_vector,
  input wire logic o_halt,
  input wire logic o_wdog_disabled,
  input wire logic [12:0] o_prescaler
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);
  logic [15:0] oe_len;
  logic [15:0] next_oe_len;
  always_comb begin
    next_oe_len = o_rst_pin_oe ? oe_len + 16'h1 : 16'h0;
  end
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      oe_len <= 16'h0;
    end else begin
      oe_len <= next_oe_len;
    end
  end
  chk_pin_low_only: assert property (o_rst_pin_out == 1'b0)
    else $error("reset pin driven high");
  chk_vector_select: assert property (o_reset_vector == (i_monitor_mode ?
    srcs_pkg::VECTOR_MONITOR : srcs_pkg::VECTOR_USER))
    else $error("reset vector wrong");
  chk_wdog_monitor_off: assert property (i_monitor_mode && (i_rst_pin_high_voltage ||
    i_irq_pin_high_voltage) |-> o_wdog_disabled)
    else $error("watchdog not disabled in monitor mode");
  chk_wdog_break_off: assert property (i_break_state && i_rst_pin_high_voltage
    |-> o_wdog_disabled)
    else $error("watchdog not disabled in break");
  chk_cpu_wait_stop: assert property (i_wait_mode |-> !o_cpu_clk_en)
    else $error("cpu clock runs in wait");
  chk_internal_reset_hold_min: assert property ($rose(o_internal_reset_n)
    |-> !$past(o_internal_reset_n, 32) && !$past(o_rst_pin_oe, 32))
    else $error("internal reset released too early");
  chk_pin_drive_len: assert property ($fell(o_rst_pin_oe)
    |-> oe_len == 16'h20 || oe_len >= STARTUP_COUNT)
    else $error("pin drive length wrong");
  chk_pin_halts: assert property (!i_rst_pin |-> ##[1:4] o_halt)
    else $error("pin low did not halt");
  chk_service_clear: assert property (i_wr && i_addr == srcs_pkg::WDOG_SERVICE_ADDR
    |-> ##1 o_prescaler[12:5] == 8'h00)
    else $error("service write kept prescaler");
endmodule
bind srcs_top srcs_checker #(.STARTUP_COUNT(STARTUP_COUNT)) u_srcs_checker (.i_mclk,
  .i_resetn, .i_wait_mode, .i_monitor_mode, .i_break_state, .i_rst_pin_high_voltage,
  .i_irq_pin_high_voltage, .i_rst_pin, .i_addr, .i_wr, .o_rst_pin_out, .o_rst_pin_oe,
  .o_internal_reset_n, .o_cpu_clk_en, .o_reset_vector, .o_halt, .o_wdog_disabled,
  .o_prescaler);

/* File: verification/srcs_tb_top.sv */
// Purpose: self-checking bench of the reset sequencer
// Assumes: short startup count of 64 and power-on pin-flag count of 131
// Notes: register reads are checked from a queue by a watcher process
`timescale 1ns/1ps
module srcs_tb_top;
  logic i_mclk, i_resetn, i_pll_select, i_pll_vco_clock, i_low_voltage_reset;
  logic i_illegal_opcode, i_illegal_fetch, i_opcode_fetch, i_wait_mode, i_monitor_mode;
  logic i_break_state, i_rst_pin_high_voltage, i_irq_pin_high_voltage, i_rst_pin;
  logic i_wr, i_rd, hold_low, rd_seen;
  logic [15:0] i_addr, o_reset_vector;
  logic [7:0] i_wdata, o_rdata, v;
  logic [12:0] o_prescaler, p0;
  logic o_rst_pin_out, o_rst_pin_oe, o_internal_reset_n, o_cpu_release, o_clock_gen_enable;
  logic o_clock_gen_output, o_bus_clk_en, o_cpu_clk_en, o_periph_clk_en_a, o_periph_clk_en_b;
  logic o_halt, o_wdog_disabled;
  logic [7:0] exp_q[$];
  int n_errors, comparisons, k, nb, nc, na, nd, ng, ne;
  srcs_top #(.STARTUP_COUNT(64), .PIN_FLAG_POR_COUNT(131)) u_srcs_top (.i_mclk(i_mclk),
    .i_resetn(i_resetn), .i_pll_select(i_pll_select), .i_pll_vco_clock(i_pll_vco_clock),
    .i_low_voltage_reset(i_low_voltage_reset), .i_illegal_opcode(i_illegal_opcode),
    .i_illegal_fetch(i_illegal_fetch), .i_opcode_fetch(i_opcode_fetch),
    .i_wait_mode(i_wait_mode), .i_monitor_mode(i_monitor_mode), .i_break_state(i_break_state),
    .i_rst_pin_high_voltage(i_rst_pin_high_voltage),
    .i_irq_pin_high_voltage(i_irq_pin_high_voltage), .i_rst_pin(i_rst_pin), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_rst_pin_out(o_rst_pin_out), .o_rst_pin_oe(o_rst_pin_oe),
    .o_internal_reset_n(o_internal_reset_n), .o_cpu_release(o_cpu_release),
    .o_clock_gen_enable(o_clock_gen_enable), .o_clock_gen_output(o_clock_gen_output),
    .o_bus_clk_en(o_bus_clk_en), .o_cpu_clk_en(o_cpu_clk_en),
    .o_periph_clk_en_a(o_periph_clk_en_a), .o_periph_clk_en_b(o_periph_clk_en_b),
    .o_reset_vector(o_reset_vector), .o_halt(o_halt), .o_wdog_disabled(o_wdog_disabled),
    .o_prescaler(o_prescaler));
  srcs_partner u_srcs_partner (.i_oe(o_rst_pin_oe), .i_out(o_rst_pin_out),
    .i_hold_low(hold_low), .o_pin(i_rst_pin));
  initial begin
    i_mclk = 1'b0;
    forever #2.5 i_mclk = ~i_mclk;
  end
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic wr(logic [15:0] a, logic [7:0] d);
    @(posedge i_mclk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(logic [15:0] a, logic [7:0] e);
    exp_q.push_back(e);
    @(posedge i_mclk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    @(posedge i_mclk);
  endtask
  task automatic wait_internal_reset(logic l, int lim);
    k = 0;
    @(negedge i_mclk);
    while (o_internal_reset_n !== l && k < lim) begin
      @(negedge i_mclk);
      k++;
    end
    chk("internal reset", {15'h0, l}, {15'h0, o_internal_reset_n});
  endtask
  task automatic wait_pre(logic [12:0] lo, logic [12:0] hi);
    for (int j = 0; j < 9000 && !(o_prescaler >= lo && o_prescaler < hi); j++) begin
      @(posedge i_mclk);
    end
    chk("prescaler window", 16'h1, {15'h0, o_prescaler >= lo && o_prescaler < hi});
  endtask
  function automatic logic [7:0] cb(int b);
    return 8'h01 << b;
  endfunction
  always @(posedge i_mclk) begin
    if (rd_seen) begin
      chk("read data", {8'h00, exp_q.pop_front()}, {8'h00, o_rdata});
    end
    rd_seen = i_rd;
    i_pll_vco_clock <= 1'($urandom);
  end
  initial begin
    repeat (60000) @(posedge i_mclk);
    n_errors++;
    report_and_stop();
  end
  initial begin
    {i_resetn, i_pll_select, i_low_voltage_reset, i_illegal_opcode} = '0;
    {i_illegal_fetch, i_opcode_fetch, i_wait_mode, i_monitor_mode, i_break_state} = '0;
    {i_rst_pin_high_voltage, i_irq_pin_high_voltage, i_wr, i_rd, hold_low} = '0;
    i_addr = 16'h0000;
    i_wdata = 8'h00;
    void'($urandom(32'hc736));
    repeat (8) @(posedge i_mclk);
    i_resetn <= 1'b1;
    @(negedge i_mclk);
    chk("pin drive", 16'h1, {15'h0, o_rst_pin_oe});
    chk("generator on", 16'h1, {15'h0, o_clock_gen_enable});
    wait_internal_reset(1'b1, 400);
    chk("release time", 16'h1, {15'h0, k >= 126 && k <= 140});
    chk("cpu release", 16'h1, {15'h0, o_cpu_release});
    rd(srcs_pkg::CAUSE_REG_ADDR, srcs_pkg::CAUSE_RESET);
    rd(srcs_pkg::WDOG_LIMIT_ADDR, srcs_pkg::WDOG_LIMIT_RESET);
    rd(16'h1234, 8'h00);
    v = 8'($urandom);
    wr(16'h1234, ~v);
    wr(srcs_pkg::WDOG_LIMIT_ADDR, v);
    rd(srcs_pkg::WDOG_LIMIT_ADDR, v);
    $display("power-on test done");
    wait_pre(13'h0400, 13'h1000);
    @(posedge i_mclk);
    i_illegal_opcode <= 1'b1;
    @(posedge i_mclk);
    i_illegal_opcode <= 1'b0;
    wait_internal_reset(1'b0, 8);
    wait_internal_reset(1'b1, 100);
    @(posedge i_mclk);
    chk("prescaler cleared", 16'h1, {15'h0, o_prescaler < 13'h0100});
    rd(srcs_pkg::CAUSE_REG_ADDR, cb(srcs_pkg::CAUSE_ILLEGAL_OPCODE_FLAG_BIT));
    rd(srcs_pkg::WDOG_LIMIT_ADDR, srcs_pkg::WDOG_LIMIT_RESET);
    @(posedge i_mclk);
    i_illegal_fetch <= 1'b1;
    repeat (10) @(negedge i_mclk);
    chk("data fetch", 16'h1, {15'h0, o_internal_reset_n});
    @(posedge i_mclk);
    i_opcode_fetch <= 1'b1;
    @(posedge i_mclk);
    {i_illegal_fetch, i_opcode_fetch} <= 2'b00;
    wait_internal_reset(1'b0, 8);
    wait_internal_reset(1'b1, 100);
    rd(srcs_pkg::CAUSE_REG_ADDR, cb(srcs_pkg::CAUSE_ILLEGAL_ADDRESS_FLAG_BIT));
    $display("internal source test done");
    for (int n = 20; n <= 80; n += 60) begin
      wait_pre(13'h0100, 13'h1000);
      p0 = o_prescaler;
      @(posedge i_mclk);
      hold_low <= 1'b1;
      repeat (n) @(negedge i_mclk);
      chk("halt", 16'h1, {15'h0, o_halt});
      @(posedge i_mclk);
      hold_low <= 1'b0;
      wait_internal_reset(1'b1, 200);
      @(posedge i_mclk);
      chk("prescaler kept", 16'h1, {15'h0, o_prescaler >= p0});
      v = cb(srcs_pkg::CAUSE_ILLEGAL_ADDRESS_FLAG_BIT) | (n > 67 ? cb(srcs_pkg::CAUSE_PIN_BIT) : 8'h00);
      rd(srcs_pkg::CAUSE_REG_ADDR, v);
    end
    @(posedge i_mclk);
    i_low_voltage_reset <= 1'b1;
    wait_internal_reset(1'b0, 8);
    @(posedge i_mclk);
    i_low_voltage_reset <= 1'b0;
    wait_internal_reset(1'b1, 400);
    chk("power style", 16'h1, {15'h0, k >= 120});
    rd(srcs_pkg::CAUSE_REG_ADDR, cb(srcs_pkg::CAUSE_LVR_BIT));
    $display("pin and low voltage test done");
    for (int i = 0; i < 16; i++) begin
      @(posedge i_mclk);
      {i_monitor_mode, i_break_state, i_rst_pin_high_voltage, i_irq_pin_high_voltage} <= 4'(i);
      @(negedge i_mclk);
      v = {7'h0, (i[3] && (i[1] || i[0])) || (i[2] && i[1])};
      chk("watchdog off", {8'h0, v}, {15'h0, o_wdog_disabled});
      chk("vector", i[3] ? 16'hfefe : 16'hfffe, o_reset_vector);
    end
    @(posedge i_mclk);
    {i_monitor_mode, i_break_state, i_rst_pin_high_voltage, i_irq_pin_high_voltage} <= 4'h0;
    i_wait_mode <= 1'b1;
    {nb, nc, na, nd, ng, ne} = '0;
    repeat (64) begin
      @(negedge i_mclk);
      {nb, nc, na, nd} = {nb + o_bus_clk_en, nc + o_cpu_clk_en, na + o_periph_clk_en_a,
        nd + o_periph_clk_en_b};
      ng = ng + o_clock_gen_output;
    end
    chk("bus pulses", 16'h10, 16'(nb));
    chk("generator high", 16'h20, 16'(ng));
    chk("cpu pulses", 16'h0, 16'(nc));
    chk("module pulses", 16'h20, 16'(na + nd));
    @(posedge i_mclk);
    i_pll_select <= 1'b1;
    nb = 0;
    repeat (64) begin
      @(negedge i_mclk);
      {ne, nb} = {ne + i_pll_vco_clock, nb + o_bus_clk_en};
    end
    chk("pll bus rate", 16'h1, {15'h0, 4 * nb + 3 >= ne && 4 * nb <= ne + 3});
    @(posedge i_mclk);
    {i_pll_select, i_wait_mode} <= 2'b00;
    $display("clock test done");
    wr(srcs_pkg::WDOG_LIMIT_ADDR, 8'h01);
    repeat (3) begin
      wr(srcs_pkg::WDOG_SERVICE_ADDR, 8'($urandom));
      repeat (6000) @(posedge i_mclk);
      chk("serviced", 16'h1, {15'h0, o_internal_reset_n});
    end
    wait_internal_reset(1'b0, 17000);
    wait_internal_reset(1'b1, 100);
    rd(srcs_pkg::CAUSE_REG_ADDR, cb(srcs_pkg::CAUSE_WDOG_BIT));
    $display("watchdog test done");
    report_and_stop();
  end
endmodule
